// File: design/mcb_branch_unit.sv
`timescale 1ns/10ps
`include "mcb_cfg.svh"

// Overview of operation
// (RQ1) Start condition met: relative jump puts next instruction at relative target.
// (RQ2) Offset field is 5-bit two's complement, range -16 to 15.
// (RQ3) Relative target is the jump's own address plus sign-extended offset.
// (RQ4) Start-select is a six-bit mask, start 1 in the lowest bit.
// (RQ5) Relative start jump when bits 15..11 are 00001; mask 10..5, offset 4..0.
// (RQ6) Status condition met: absolute jump loads counter from named jump register.
// (RQ7) Status-select code picks one control/status bit, 0000 is bit 0.
// (RQ8) Polarity 0 needs selected bit zero; polarity 1 needs it one.
// (RQ9) Absolute jump: bits 15..10 001111, 3..0 0101; pol 9, select 8..5, reg 4.
// (RQ10) Register operand picks a jump register; its address may be anywhere.
// (RQ11) Condition not met: counter advances to next sequential instruction only.
module mcb_branch_unit
	import mcb_pkg::*;
#(
	parameter int PC_W = `MCB_PC_W
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic instr_valid,
	input wire logic [`MCB_INSTR_W-1:0] instr_word,
	input wire logic [`MCB_START_W-1:0] start_latch,
	input wire logic [`MCB_STATUS_W-1:0] core_control_status,
	input wire logic [`MCB_NUM_JREGS-1:0][PC_W-1:0] jump_register_subset,
	output logic [PC_W-1:0] program_counter,
	output mcb_branch_s branch_status,
	output logic [PC_W-1:0] branch_target
);

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	mcb_decode_s dec;
	logic [PC_W-1:0] ofs_ext;
	logic [PC_W-1:0] rel_target;
	logic [PC_W-1:0] abs_target;
	logic [PC_W-1:0] seq_pc;
	logic start_ok;
	logic status_ok;

	always_comb begin
		dec = '0;
		dec.rel_start = instr_word[`MCB_REL_OP_HI:`MCB_REL_OP_LO] == `MCB_REL_OP; // [RQ5]
		dec.abs_status = (instr_word[`MCB_ABS_OP_HI:`MCB_ABS_OP_LO] == `MCB_ABS_OP) // [RQ9]
			&& (instr_word[`MCB_ABS_TAIL_HI:`MCB_ABS_TAIL_LO] == `MCB_ABS_TAIL);
		dec.start_mask = instr_word[`MCB_MASK_HI:`MCB_MASK_LO]; // [RQ5]
		dec.offset = instr_word[`MCB_OFS_HI:`MCB_OFS_LO]; // [RQ5]
		dec.polarity = instr_word[`MCB_POL_BIT]; // [RQ9]
		dec.status_sel = instr_word[`MCB_SSEL_HI:`MCB_SSEL_LO]; // [RQ9]
		dec.jreg_sel = instr_word[`MCB_JREG_BIT]; // [RQ9]
	end

	// Top offset bit is the sign
	assign ofs_ext = {{(PC_W-`MCB_OFS_W){dec.offset[`MCB_OFS_W-1]}}, dec.offset}; // [RQ2]
	// Wraps modulo the Code RAM size, like the counter itself
	assign rel_target = program_counter + ofs_ext; // [RQ3]
	assign seq_pc = program_counter + PC_W'(1);
	// Exact match: mask 000000 means no start may be latched
	assign start_ok = start_latch == dec.start_mask; // [RQ4]
	assign status_ok = core_control_status[dec.status_sel] == dec.polarity; // [RQ7] [RQ8]
	assign abs_target = jump_register_subset[dec.jreg_sel]; // [RQ10]

	// ----------------------------------------
	// Program counter sequencing
	// ----------------------------------------
	mcb_state_e state;
	mcb_state_e next_state;
	logic [PC_W-1:0] next_program_counter;
	mcb_branch_s next_branch_status;
	logic [PC_W-1:0] next_branch_target;

	always_comb begin
		next_state = state;
		next_program_counter = program_counter;
		next_branch_status = '0;
		next_branch_target = branch_target;
		case (state)
			mcb_st_boot: begin
				// One idle cycle so fetch sees the reset address first
				next_program_counter = PC_W'(`MCB_RESET_PC);
				next_branch_target = PC_W'(`MCB_RESET_PC);
				next_state = mcb_st_run;
			end
			mcb_st_run: begin
				if (instr_valid) begin
					if (dec.rel_start && start_ok) begin
						next_program_counter = rel_target; // [RQ1] [RQ3]
						next_branch_target = rel_target;
						next_branch_status.taken = 1'b1;
						next_branch_status.rel_jump = 1'b1;
					end else if (dec.abs_status && status_ok) begin
						next_program_counter = abs_target; // [RQ6] [RQ10]
						next_branch_target = abs_target;
						next_branch_status.taken = 1'b1;
						next_branch_status.abs_jump = 1'b1;
					end else begin
						// Unmet condition and every other opcode fall through
						next_program_counter = seq_pc; // [RQ11]
					end
				end
			end
			default: begin
				next_state = mcb_st_boot;
				next_program_counter = PC_W'(`MCB_RESET_PC);
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= mcb_st_boot;
			program_counter <= PC_W'(`MCB_RESET_PC);
			branch_status <= '0;
			branch_target <= PC_W'(`MCB_RESET_PC);
		end else begin
			state <= next_state;
			program_counter <= next_program_counter;
			branch_status <= next_branch_status;
			branch_target <= next_branch_target;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	logic accept;
	assign accept = instr_valid && (state == mcb_st_run);
	// Expected offset built apart from the decode path
	logic [PC_W-1:0] chk_ofs;
	assign chk_ofs = PC_W'($signed(instr_word[`MCB_OFS_HI:`MCB_OFS_LO]));

	rel_jump_taken_a: assert property ( // [RQ1]
		accept && dec.rel_start && start_ok
		|=> branch_status.taken && branch_status.rel_jump
			&& program_counter == branch_target)
		else $error("relative start jump not taken");

	rel_target_sum_a: assert property ( // [RQ3]
		accept && dec.rel_start && start_ok
		|=> program_counter == $past(program_counter) + $past(chk_ofs))
		else $error("relative target is not address plus offset");

	neg_offset_a: assert property ( // [RQ2]
		accept && dec.rel_start && start_ok && dec.offset == 5'h10
		|=> program_counter == $past(program_counter) - PC_W'(16))
		else $error("offset -16 not applied");

	pos_offset_a: assert property ( // [RQ2]
		accept && dec.rel_start && start_ok && dec.offset == 5'h0f
		|=> program_counter == $past(program_counter) + PC_W'(15))
		else $error("offset 15 not applied");

	start_mask_a: assert property ( // [RQ4]
		accept && dec.rel_start && start_latch != dec.start_mask
		|=> !branch_status.taken
			&& program_counter == $past(program_counter) + PC_W'(1))
		else $error("relative jump taken with unmatched start mask");

	rel_decode_a: assert property ( // [RQ5]
		accept && instr_word[15:11] != 5'h01
		|=> !branch_status.rel_jump)
		else $error("relative jump from wrong opcode");

	abs_jump_taken_a: assert property ( // [RQ6]
		accept && dec.abs_status && status_ok && !instr_word[4]
		|=> branch_status.abs_jump && program_counter == $past(jump_register_subset[0]))
		else $error("absolute jump did not load jump register 0");

	abs_jump_reg1_a: assert property ( // [RQ10]
		accept && dec.abs_status && status_ok && instr_word[4]
		|=> branch_status.abs_jump && program_counter == $past(jump_register_subset[1]))
		else $error("absolute jump did not load jump register 1");

	status_bit_a: assert property ( // [RQ7]
		accept && dec.abs_status
			&& core_control_status[instr_word[8:5]] == instr_word[9]
		|=> branch_status.taken)
		else $error("selected status bit ignored");

	polarity_a: assert property ( // [RQ8]
		accept && dec.abs_status
			&& core_control_status[instr_word[8:5]] != instr_word[9]
		|=> !branch_status.taken
			&& program_counter == $past(program_counter) + PC_W'(1))
		else $error("absolute jump taken with wrong polarity");

	abs_decode_a: assert property ( // [RQ9]
		accept && instr_word[15:10] == 6'h0f && instr_word[3:0] != 4'h5
		|=> !branch_status.abs_jump)
		else $error("absolute jump from wrong tail bits");

	sequential_a: assert property ( // [RQ11]
		accept && !(dec.rel_start && start_ok) && !(dec.abs_status && status_ok)
		|=> program_counter == $past(program_counter) + PC_W'(1)
			&& branch_target == $past(branch_target)
			&& branch_status == '0)
		else $error("fall-through did not advance by one");

	hold_idle_a: assert property ( // [RQ11]
		state == mcb_st_run && !instr_valid
		|=> $stable(program_counter) [*1] ##0 !branch_status.taken)
		else $error("counter moved without an instruction");

	// Cross-checks on the outputs, several from the raw instruction bits
	boot_hold_a: assert property ( // [RQ11]
		state == mcb_st_boot
		|=> program_counter == PC_W'(`MCB_RESET_PC) && branch_status == '0)
		else $error("boot cycle moved the counter");

	target_hold_a: assert property ( // [RQ11]
		!$stable(branch_target) |-> branch_status.taken)
		else $error("target changed without a taken jump");

	target_on_taken_a: assert property ( // [RQ10]
		branch_status.taken |-> branch_target == program_counter)
		else $error("target differs from the new counter");

	status_code_a: assert property ( // [RQ1]
		branch_status == '0 || branch_status == 3'b110
			|| branch_status == 3'b101)
		else $error("illegal branch status code");

	offset_range_a: assert property ( // [RQ2]
		branch_status.rel_jump
		|-> PC_W'(program_counter - $past(program_counter) + PC_W'(16)) < PC_W'(32))
		else $error("relative step outside -16 to 15");

	rel_sign_a: assert property ( // [RQ2]
		accept && instr_word[15:11] == 5'h01 && start_latch == instr_word[10:5]
			&& instr_word[4]
		|=> PC_W'($past(program_counter) - program_counter - PC_W'(1)) < PC_W'(16))
		else $error("negative offset did not move back");

	zero_offset_a: assert property ( // [RQ3]
		accept && dec.rel_start && start_ok && instr_word[4:0] == 5'h00
		|=> $stable(program_counter) && branch_status.rel_jump)
		else $error("zero offset did not target the jump itself");

	mask_all_a: assert property ( // [RQ4]
		accept && instr_word[15:11] == 5'h01 && instr_word[10:5] == 6'h3f
			&& start_latch == 6'h3f
		|=> branch_status.rel_jump)
		else $error("all-starts mask not honoured");

	mask_none_a: assert property ( // [RQ4]
		accept && instr_word[15:11] == 5'h01 && instr_word[10:5] == 6'h00
			&& start_latch != 6'h00
		|=> !branch_status.taken)
		else $error("no-start mask jumped with a start latched");

	mask_match_a: assert property ( // [RQ4]
		accept && instr_word[15:11] == 5'h01 && start_latch == instr_word[10:5]
		|=> branch_status.rel_jump)
		else $error("matching start mask not taken");

	rel_no_abs_a: assert property ( // [RQ5]
		accept && dec.rel_start
		|=> !branch_status.abs_jump)
		else $error("relative opcode raised an absolute jump");

	status_msb_a: assert property ( // [RQ7]
		accept && dec.abs_status && instr_word[8:5] == 4'hf
			&& core_control_status[15] == instr_word[9]
		|=> branch_status.abs_jump)
		else $error("status bit 15 not selected by code 1111");

	pol_low_a: assert property ( // [RQ8]
		accept && dec.abs_status && !instr_word[9]
			&& !core_control_status[instr_word[8:5]]
		|=> branch_status.abs_jump)
		else $error("low polarity with bit zero not taken");

	pol_high_a: assert property ( // [RQ8]
		accept && dec.abs_status && instr_word[9]
			&& core_control_status[instr_word[8:5]]
		|=> branch_status.abs_jump)
		else $error("high polarity with bit one not taken");

	abs_no_rel_a: assert property ( // [RQ9]
		accept && dec.abs_status
		|=> !branch_status.rel_jump)
		else $error("absolute opcode raised a relative jump");

	idle_target_a: assert property ( // [RQ11]
		state == mcb_st_run && !instr_valid
		|=> $stable(branch_target))
		else $error("target moved without an instruction");

	// Scenarios the bench is meant to reach

	rel_taken_c: cover property (
		accept && dec.rel_start && start_ok && dec.offset[4]);
	abs_taken_c: cover property (
		accept && dec.abs_status && status_ok && dec.jreg_sel);
	abs_refused_c: cover property (
		accept && dec.abs_status && !status_ok);
	back_to_back_c: cover property (
		accept && dec.rel_start && start_ok ##1 accept && dec.abs_status && status_ok);
	boot_refused_c: cover property (
		state == mcb_st_boot && instr_valid);

endmodule

// File: design/mcb_cfg.svh
`ifndef MCB_CFG_SVH
`define MCB_CFG_SVH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define MCB_PC_W 10
`define MCB_RESET_PC 10'h000
`define MCB_INSTR_W 16
`define MCB_START_W 6
`define MCB_OFS_W 5
`define MCB_SSEL_W 4
`define MCB_STATUS_W 16
`define MCB_NUM_JREGS 2

// ----------------------------------------
// Opcode values
// ----------------------------------------
`define MCB_REL_OP 5'h01
`define MCB_ABS_OP 6'h0f
`define MCB_ABS_TAIL 4'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCB_REL_OP_HI 15
`define MCB_REL_OP_LO 11
`define MCB_ABS_OP_HI 15
`define MCB_ABS_OP_LO 10
`define MCB_ABS_TAIL_HI 3
`define MCB_ABS_TAIL_LO 0
`define MCB_MASK_HI 10
`define MCB_MASK_LO 5
`define MCB_OFS_HI 4
`define MCB_OFS_LO 0
`define MCB_POL_BIT 9
`define MCB_SSEL_HI 8
`define MCB_SSEL_LO 5
`define MCB_JREG_BIT 4

`endif

// File: design/mcb_pkg.sv
`include "mcb_cfg.svh"

package mcb_pkg;

	typedef enum logic [1:0] {
		mcb_st_boot = 2'b01,
		mcb_st_run = 2'b10
	} mcb_state_e;

	typedef struct packed {
		logic rel_start;
		logic abs_status;
		logic [`MCB_START_W-1:0] start_mask;
		logic [`MCB_OFS_W-1:0] offset;
		logic polarity;
		logic [`MCB_SSEL_W-1:0] status_sel;
		logic jreg_sel;
	} mcb_decode_s;

	typedef struct packed {
		logic taken;
		logic rel_jump;
		logic abs_jump;
	} mcb_branch_s;

endpackage

// File: dv/mcb_code_ram.sv
`timescale 1ns/10ps
`include "mcb_cfg.svh"

// ----------------------------------------
// Code RAM fetch model
// ----------------------------------------
module mcb_code_ram
	import mcb_pkg::*;
#(
	parameter int PC_W = `MCB_PC_W
) (
	input wire logic [PC_W-1:0] program_counter,
	output logic [`MCB_INSTR_W-1:0] instr_word
);
	logic [`MCB_INSTR_W-1:0] mem [2**PC_W];
	// Blank words decode as no branch
	initial begin
		foreach (mem[i]) begin
			mem[i] = 16'hffff;
		end
	end
	// Word always reflects the current counter, no fetch latency
	assign instr_word = mem[program_counter];
endmodule

// File: dv/tb.sv
`timescale 1ns/10ps
`include "mcb_cfg.svh"

module tb
	import mcb_pkg::*;
;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic instr_valid = 1'b0;
	logic [15:0] instr_word;
	logic [5:0] start_latch = 6'h00;
	logic [15:0] core_control_status = 16'h0000;
	logic [1:0][9:0] jump_register_subset = {10'h13c, 10'h2a5};
	logic [9:0] program_counter;
	logic [9:0] branch_target;
	logic [9:0] cur_pc;
	logic [9:0] tgt;
	mcb_branch_s branch_status;
	int error_cnt = 0;
	int n_compared = 0;

	initial forever #2.5 sys_clk = ~sys_clk;

	mcb_branch_unit mcb_branch_unit_i (.sys_clk(sys_clk), .resetn(resetn),
		.instr_valid(instr_valid), .instr_word(instr_word), .start_latch(start_latch),
		.core_control_status(core_control_status),
		.jump_register_subset(jump_register_subset), .program_counter(program_counter),
		.branch_status(branch_status), .branch_target(branch_target));
	mcb_code_ram mcb_code_ram_i (.program_counter(program_counter), .instr_word(instr_word));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [9:0] rel(input logic [4:0] o);
		return cur_pc + {{5{o[4]}}, o};
	endfunction

	// One instruction at the current counter; bs of zero means fall through
	task automatic exec(input logic [15:0] w, input logic [5:0] st, input logic [15:0] cs,
		input logic [9:0] dst, input logic [2:0] bs);
		@(posedge sys_clk);
		mcb_code_ram_i.mem[cur_pc] <= w;
		start_latch <= st;
		core_control_status <= cs;
		instr_valid <= 1'b1;
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		#1;
		cur_pc = bs[2] ? dst : cur_pc + 10'h001;
		if (bs[2]) begin
			tgt = dst;
		end
		chk(program_counter, cur_pc);
		chk(branch_status, bs);
		chk(branch_target, tgt);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_rel();
		exec({5'h01, 6'h3f, 5'h10}, 6'h3f, 16'h0000, rel(5'h10), 3'h6);
		exec({5'h01, 6'h00, 5'h0f}, 6'h00, 16'h0000, rel(5'h0f), 3'h6);
		exec({5'h01, 6'h01, 5'h03}, 6'h03, 16'h0000, 10'h000, 3'h0);
		exec({5'h01, 6'h20, 5'h00}, 6'h20, 16'h0000, rel(5'h00), 3'h6);
		exec({5'h01, 6'h00, 5'h05}, 6'h01, 16'h0000, 10'h000, 3'h0);
	endtask

	task automatic t_abs();
		logic [15:0] cs;
		logic [15:0] w;
		for (int i = 0; i < 4; i++) begin
			cs = 16'h0001 << (i[1] ? 15 : 0);
			if (!i[0]) begin
				cs = ~cs;
			end
			w = {6'h0f, i[0], i[1] ? 4'hf : 4'h0, i[0] ^ i[1], 4'h5};
			exec(w, 6'h00, cs, jump_register_subset[i[0] ^ i[1]], 3'h5);
			exec(w, 6'h00, ~cs, 10'h000, 3'h0);
		end
	endtask

	task automatic t_other();
		exec(16'h3c01, 6'h00, 16'h0000, 10'h000, 3'h0);
		exec({6'h0f, 1'b1, 4'h0, 1'b0, 4'h4}, 6'h00, 16'hffff, 10'h000, 3'h0);
		exec({5'h11, 6'h00, 5'h05}, 6'h00, 16'h0000, 10'h000, 3'h0);
		exec({5'h01, 6'h00, 5'h05}, 6'h00, 16'h0000, rel(5'h05), 3'h6);
		@(posedge sys_clk);
		#1;
		chk(branch_status, 3'h0);
		chk(program_counter, cur_pc);
	endtask

	// Two accepted jumps on consecutive edges
	task automatic t_b2b();
		@(posedge sys_clk);
		mcb_code_ram_i.mem[cur_pc] <= {5'h01, 6'h15, 5'h02};
		mcb_code_ram_i.mem[cur_pc + 10'h002] <= {6'h0f, 1'b1, 4'h3, 1'b1, 4'h5};
		start_latch <= 6'h15;
		core_control_status <= 16'h0008;
		instr_valid <= 1'b1;
		@(posedge sys_clk);
		#1;
		cur_pc = cur_pc + 10'h002;
		tgt = cur_pc;
		chk(program_counter, cur_pc);
		chk(branch_status, 3'h6);
		chk(branch_target, tgt);
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		#1;
		cur_pc = jump_register_subset[1];
		tgt = cur_pc;
		chk(program_counter, cur_pc);
		chk(branch_status, 3'h5);
		chk(branch_target, tgt);
	endtask

	// Mid-run reset; the boot cycle must ignore a pending jump
	task automatic t_reset();
		@(posedge sys_clk);
		mcb_code_ram_i.mem[10'h000] <= {5'h01, 6'h00, 5'h05};
		start_latch <= 6'h00;
		resetn <= 1'b0;
		instr_valid <= 1'b1;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		instr_valid <= 1'b0;
		#1;
		cur_pc = 10'h000;
		tgt = 10'h000;
		chk(program_counter, cur_pc);
		chk(branch_status, 3'h0);
		chk(branch_target, tgt);
		@(posedge sys_clk);
		#1;
		chk(program_counter, cur_pc);
		chk(branch_status, 3'h0);
		exec({5'h01, 6'h00, 5'h05}, 6'h00, 16'h0000, rel(5'h05), 3'h6);
	endtask

	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		cur_pc = 10'h000;
		tgt = 10'h000;
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		// Boot cycle follows the release edge
		repeat (2) @(posedge sys_clk);
		#1;
		chk(program_counter, 10'h000);
		chk(branch_status, 3'h0);
		chk(branch_target, 10'h000);
		t_rel();
		t_abs();
		t_other();
		t_b2b();
		t_reset();
		report_and_stop();
	end
endmodule
